// File: rcp_pkg.sv
// Package: register map, field positions and states of the reset controller
`default_nettype none
package rcp_pkg;
  localparam logic [7:0]  OFF_CTRL   = 8'h0c;
  localparam logic [7:0]  OFF_PWR    = 8'h10;
  localparam logic [7:0]  OFF_STAT   = 8'h30;
  localparam logic [7:0]  OFF_CLR    = 8'h34;
  localparam int          CTRL_SOFT  = 2;
  localparam int          CTRL_TPIN  = 1;
  localparam int          PWR_PORDIS = 5;
  localparam int          PWR_PD     = 4;
  localparam int          PWR_IO     = 3;
  localparam int          PWR_OSC    = 2;
  localparam int          PWR_FBCK   = 1;
  localparam int          PWR_BCK    = 0;
  localparam int          ST_SOFT    = 10;
  localparam int          ST_DSYS    = 9;
  localparam int          ST_SYS     = 8;
  localparam int          ST_FAB     = 7;
  localparam int          ST_WDOG    = 6;
  localparam int          ST_DCPU    = 5;
  localparam int          ST_CPU     = 4;
  localparam int          ST_DCFG    = 3;
  localparam int          ST_PIN     = 2;
  localparam int          ST_CFG     = 1;
  localparam int          ST_POR     = 0;
  localparam int          ST_W       = 11;
  localparam int          PWR_W      = 6;
  localparam logic [2:0]  CTRL_RST   = 3'h0;
  localparam logic [5:0]  PWR_RST    = 6'h00;
  localparam logic [10:0] STAT_POR   = 11'h001;
  localparam logic [3:0]  SYSRST_LEN = 4'h8;
  typedef enum logic [1:0] {RCP_RUN, RCP_SYSRST, RCP_PDOWN} rcp_state_e;
endpackage
`default_nettype wire

// File: rcp_reset_ctrl.sv
// Reset-cause recording, soft system reset and power-down gating
`default_nettype none
module rcp_reset_ctrl (
  input  wire logic        CLOCK_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        POR_EVENT_IN,
  input  wire logic        EXT_RESET_N_IN,
  input  wire logic        DEBUG_CFG_RESET_IN,
  input  wire logic        DEBUG_SYS_RESET_IN,
  input  wire logic        DEBUG_CPU_RESET_IN,
  input  wire logic        WATCHDOG_RESET_IN,
  input  wire logic        FABRIC_RESET_REQUEST_IN,
  input  wire logic        IRQ_ANY_IN,
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic [31:0]      WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  output logic             SYSTEM_RESET_INDICATION_N_OUT,
  output logic             CPU_RESET_N_OUT,
  output logic             CONFIG_RESET_N_OUT,
  output logic             RING_OSC_STOP_OUT,
  output logic             PIO_STOP_OUT,
  output logic             SYS_CLOCK_STOP_OUT,
  output logic             FABRIC_CLOCK_STOP_OUT,
  output logic             POR_DISABLE_OUT,
  output logic             RING_OSC_SELECT_OUT
);

  typedef struct packed {
    rcp_pkg::rcp_state_e st;
    logic [3:0]          cnt;
    logic [2:0]          ctrl;
    logic [5:0]          pwr;
    logic [10:0]         stat;
    logic [31:0]         dat;
    logic                ack;
    logic                sysrst_n;
    logic                cpurst_n;
    logic                cfgrst_n;
    logic                osc_stop;
    logic                pio_stop;
    logic                clk_stop;
    logic                fclk_stop;
    logic                ring_sel;
  } rcp_state_s;

  rcp_state_s q, d;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic       wr, rd_take, soft_go, cfg_ev, sys_ev, cpu_ev;
  logic [10:0] set_v, clr_v;

  always_comb begin
    wr       = WB_CYC_IN && WB_STB_IN && WB_WE_IN && !q.ack && WB_SEL_IN[0];
    rd_take  = WB_CYC_IN && WB_STB_IN && !q.ack;
    soft_go  = wr && hit(WB_ADR_IN, rcp_pkg::OFF_CTRL)
               && WB_DAT_IN[rcp_pkg::CTRL_SOFT];
    cfg_ev   = !EXT_RESET_N_IN || DEBUG_CFG_RESET_IN;
    sys_ev   = cfg_ev || soft_go || DEBUG_SYS_RESET_IN
               || WATCHDOG_RESET_IN || FABRIC_RESET_REQUEST_IN;
    cpu_ev   = sys_ev || DEBUG_CPU_RESET_IN;
    set_v    = '0;
    set_v[rcp_pkg::ST_SOFT] = soft_go;
    set_v[rcp_pkg::ST_DSYS] = DEBUG_SYS_RESET_IN;
    set_v[rcp_pkg::ST_SYS]  = sys_ev;
    set_v[rcp_pkg::ST_FAB]  = FABRIC_RESET_REQUEST_IN;
    set_v[rcp_pkg::ST_WDOG] = WATCHDOG_RESET_IN;
    set_v[rcp_pkg::ST_DCPU] = DEBUG_CPU_RESET_IN;
    set_v[rcp_pkg::ST_CPU]  = cpu_ev;
    set_v[rcp_pkg::ST_DCFG] = DEBUG_CFG_RESET_IN;
    set_v[rcp_pkg::ST_PIN]  = !EXT_RESET_N_IN;
    set_v[rcp_pkg::ST_CFG]  = cfg_ev;
    set_v[rcp_pkg::ST_POR]  = POR_EVENT_IN;
    clr_v = '0;
    if (wr && hit(WB_ADR_IN, rcp_pkg::OFF_CLR)) begin
      clr_v = WB_DAT_IN[rcp_pkg::ST_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d     = q;
    d.ack = rd_take;
    d.dat = '0;
    // Sticky flags, set beats clear
    d.stat = (q.stat & ~clr_v) | set_v;
    if (wr && hit(WB_ADR_IN, rcp_pkg::OFF_CTRL)) begin
      // Soft request bit never stored: it only launches the sequence
      d.ctrl[rcp_pkg::CTRL_TPIN] = WB_DAT_IN[rcp_pkg::CTRL_TPIN];
    end
    if (wr && hit(WB_ADR_IN, rcp_pkg::OFF_PWR)) begin
      d.pwr = WB_DAT_IN[rcp_pkg::PWR_W-1:0];
    end
    if (rd_take && !WB_WE_IN) begin
      case (WB_ADR_IN)
        rcp_pkg::OFF_CTRL: d.dat = {29'h0, q.ctrl};
        rcp_pkg::OFF_PWR:  d.dat = {26'h0, q.pwr};
        rcp_pkg::OFF_STAT: d.dat = {21'h0, q.stat};
        default:           d.dat = '0;
      endcase
    end
    // Wake: interrupt drops power-down request
    if (IRQ_ANY_IN) begin
      d.pwr[rcp_pkg::PWR_PD] = 1'b0;
    end
    if (cfg_ev) begin
      d.ctrl = rcp_pkg::CTRL_RST;
      d.ring_sel = 1'b1;
    end
    if (sys_ev) begin
      // System reset keeps configuration, clears power control
      d.pwr = rcp_pkg::PWR_RST;
      d.st  = rcp_pkg::RCP_SYSRST;
      d.cnt = rcp_pkg::SYSRST_LEN;
    end else begin
      case (q.st)
        rcp_pkg::RCP_RUN: begin
          if (d.pwr[rcp_pkg::PWR_PD]) begin
            d.st = rcp_pkg::RCP_PDOWN;
          end
        end
        rcp_pkg::RCP_SYSRST: begin
          if (q.cnt == 4'h0) begin
            d.st = rcp_pkg::RCP_RUN;
          end else begin
            d.cnt = q.cnt - 4'h1;
          end
        end
        rcp_pkg::RCP_PDOWN: begin
          if (!d.pwr[rcp_pkg::PWR_PD]) begin
            d.st = rcp_pkg::RCP_RUN;
            d.ring_sel = 1'b1;
          end
        end
        default: d.st = rcp_pkg::RCP_RUN;
      endcase
    end
    if (wr && hit(WB_ADR_IN, rcp_pkg::OFF_PWR)
        && !WB_DAT_IN[rcp_pkg::PWR_PD]) begin
      d.ring_sel = 1'b0;
    end
    d.sysrst_n  = (d.st != rcp_pkg::RCP_SYSRST);
    d.cpurst_n  = d.sysrst_n && !DEBUG_CPU_RESET_IN;
    d.cfgrst_n  = !cfg_ev;
    d.osc_stop  = (d.st == rcp_pkg::RCP_PDOWN) && d.pwr[rcp_pkg::PWR_OSC];
    d.pio_stop  = (d.st == rcp_pkg::RCP_PDOWN) && d.pwr[rcp_pkg::PWR_IO];
    d.clk_stop  = (d.st == rcp_pkg::RCP_PDOWN) && d.pwr[rcp_pkg::PWR_BCK];
    d.fclk_stop = (d.st == rcp_pkg::RCP_PDOWN)
                  && d.pwr[rcp_pkg::PWR_FBCK];
  end

  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      q          <= '0;
      q.st       <= rcp_pkg::RCP_RUN;
      q.stat     <= rcp_pkg::STAT_POR;
      q.sysrst_n <= 1'b1;
      q.cpurst_n <= 1'b1;
      q.cfgrst_n <= 1'b1;
      q.ring_sel <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign WB_DAT_OUT                    = q.dat;
  assign WB_ACK_OUT                    = q.ack;
  assign SYSTEM_RESET_INDICATION_N_OUT = q.sysrst_n;
  assign CPU_RESET_N_OUT               = q.cpurst_n;
  assign CONFIG_RESET_N_OUT            = q.cfgrst_n;
  assign RING_OSC_STOP_OUT             = q.osc_stop;
  assign PIO_STOP_OUT                  = q.pio_stop;
  assign SYS_CLOCK_STOP_OUT            = q.clk_stop;
  assign FABRIC_CLOCK_STOP_OUT         = q.fclk_stop;
  assign POR_DISABLE_OUT               = q.pwr[rcp_pkg::PWR_PORDIS];
  assign RING_OSC_SELECT_OUT           = q.ring_sel;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RESETN_IN);

  chk_soft_flag_set: assert property (
    soft_go |=> q.stat[rcp_pkg::ST_SOFT])
    else $error("soft reset flag not set");
  chk_soft_rst_pulse: assert property (
    soft_go |=> !SYSTEM_RESET_INDICATION_N_OUT[*8])
    else $error("soft reset indication too short");
  chk_ctrl_selfclr: assert property (
    q.ctrl[rcp_pkg::CTRL_SOFT] == 1'b0)
    else $error("soft request bit stuck");
  chk_sticky_flags: assert property (
    (clr_v == '0) |=> ((q.stat & $past(q.stat)) == $past(q.stat)))
    else $error("flag dropped without clear");
  chk_set_beats_clr: assert property (
    (set_v & clr_v) != '0 |=> (q.stat & $past(set_v)) == $past(set_v))
    else $error("set lost against clear");
  chk_clear_works: assert property (
    clr_v[rcp_pkg::ST_POR] && !set_v[rcp_pkg::ST_POR]
    |=> !q.stat[rcp_pkg::ST_POR])
    else $error("clear ignored");
  chk_wdog_flag: assert property (
    WATCHDOG_RESET_IN |=> q.stat[rcp_pkg::ST_WDOG])
    else $error("watchdog flag not set");
  chk_pin_cfg: assert property (
    !EXT_RESET_N_IN |=> q.stat[rcp_pkg::ST_PIN] && q.stat[rcp_pkg::ST_CFG]
    && q.stat[rcp_pkg::ST_SYS])
    else $error("pin reset flags missing");
  chk_cfg_ctrl_zero: assert property (
    cfg_ev |=> q.ctrl == rcp_pkg::CTRL_RST)
    else $error("control not cleared");
  chk_pd_wake: assert property (
    IRQ_ANY_IN && !sys_ev |=> ##1 !SYS_CLOCK_STOP_OUT)
    else $error("interrupt did not wake");
  chk_cpu_flag: assert property (
    sys_ev |=> q.stat[rcp_pkg::ST_CPU])
    else $error("cpu flag missing");

  // ---------------------------------------------------------------
  // Further source flags and sideband outputs
  // ---------------------------------------------------------------
  chk_fab_flag: assert property (
    FABRIC_RESET_REQUEST_IN |=> q.stat[rcp_pkg::ST_FAB])
    else $error("fabric flag not set");
  chk_dsys_flag: assert property (
    DEBUG_SYS_RESET_IN |=> q.stat[rcp_pkg::ST_DSYS])
    else $error("debug system flag not set");
  chk_dcpu_flag: assert property (
    DEBUG_CPU_RESET_IN |=> q.stat[rcp_pkg::ST_DCPU])
    else $error("debug cpu flag not set");
  chk_dcfg_flag: assert property (
    DEBUG_CFG_RESET_IN |=> q.stat[rcp_pkg::ST_DCFG])
    else $error("debug config flag not set");
  chk_por_flag: assert property (
    POR_EVENT_IN |=> q.stat[rcp_pkg::ST_POR])
    else $error("power-on flag not set");
  chk_sys_ind_low: assert property (
    sys_ev |=> !SYSTEM_RESET_INDICATION_N_OUT)
    else $error("system reset indication missing");
  chk_cfg_out_low: assert property (
    cfg_ev |=> !CONFIG_RESET_N_OUT)
    else $error("config reset output missing");
  chk_stat_wr_ign: assert property (
    wr && hit(WB_ADR_IN, rcp_pkg::OFF_STAT) && set_v == '0
    |=> q.stat == $past(q.stat))
    else $error("status write took effect");
  chk_pd_enter: assert property (
    wr && hit(WB_ADR_IN, rcp_pkg::OFF_PWR) && WB_DAT_IN[rcp_pkg::PWR_PD]
    && WB_DAT_IN[rcp_pkg::PWR_BCK] && !sys_ev && !IRQ_ANY_IN
    |=> SYS_CLOCK_STOP_OUT)
    else $error("bus clock not stopped");
  chk_wake_ring: assert property (
    q.st == rcp_pkg::RCP_PDOWN && IRQ_ANY_IN && !sys_ev && !wr
    |=> RING_OSC_SELECT_OUT)
    else $error("ring oscillator not selected on wake");
  chk_ack_pulse: assert property (
    WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack longer than one cycle");
  cov_soft: cover property (soft_go ##10 SYSTEM_RESET_INDICATION_N_OUT);
  cov_pd: cover property (q.st == rcp_pkg::RCP_PDOWN ##1 IRQ_ANY_IN);
  cov_race: cover property ((set_v & clr_v) != '0);
  cov_dcpu: cover property (DEBUG_CPU_RESET_IN ##1 !CPU_RESET_N_OUT);
endmodule
`default_nettype wire

// File: rcp_far_end.sv
// Far-side model: reset sources and interrupt line around the controller
`default_nettype none
module rcp_far_end (
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       go_in,
  input  wire logic [3:0] code_in,
  output logic            por_out,
  output logic            ext_n_out,
  output logic            dcfg_out,
  output logic            dsys_out,
  output logic            dcpu_out,
  output logic            wdog_out,
  output logic            fab_out,
  output logic            irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] hit;
  assign hit = go_in ? (16'h0001 << code_in) : 16'h0000;
  // One-cycle event per command, launched right after the edge
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      por_out   <= 1'b0;
      ext_n_out <= 1'b1;
      dcfg_out  <= 1'b0;
      dsys_out  <= 1'b0;
      dcpu_out  <= 1'b0;
      wdog_out  <= 1'b0;
      fab_out   <= 1'b0;
      irq_out   <= 1'b0;
    end else begin
      por_out   <= hit[0];
      ext_n_out <= ~hit[1];
      dcfg_out  <= hit[2];
      dsys_out  <= hit[3];
      dcpu_out  <= hit[4];
      wdog_out  <= hit[5];
      fab_out   <= hit[6];
      irq_out   <= hit[8];
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the reset-cause and power-down controller
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, cyc, stb, we, go, ack, ind_n, cpu_n, cfg_n;
  logic pd_osc, pd_io, pd_sys, pd_fab, por_dis, ring_sel;
  logic por, ext_n, dcfg, dsys, dcpu, wdog, fab, irq;
  logic [7:0]  adr;
  logic [3:0]  sel, code;
  logic [31:0] wdat, rdat, q, r;
  logic [10:0] e;
  int          failures, samples_checked, seed, low_cnt, cpu_low, cfg_low;
  rcp_far_end rcp_far_end_i (.clk_in(clk), .rstn_in(rstn), .go_in(go),
    .code_in(code), .por_out(por), .ext_n_out(ext_n), .dcfg_out(dcfg),
    .dsys_out(dsys), .dcpu_out(dcpu), .wdog_out(wdog), .fab_out(fab),
    .irq_out(irq));
  rcp_reset_ctrl rcp_reset_ctrl_i (.CLOCK_IN(clk), .RESETN_IN(rstn),
    .POR_EVENT_IN(por), .EXT_RESET_N_IN(ext_n), .DEBUG_CFG_RESET_IN(dcfg),
    .DEBUG_SYS_RESET_IN(dsys), .DEBUG_CPU_RESET_IN(dcpu),
    .WATCHDOG_RESET_IN(wdog), .FABRIC_RESET_REQUEST_IN(fab),
    .IRQ_ANY_IN(irq), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .SYSTEM_RESET_INDICATION_N_OUT(ind_n),
    .CPU_RESET_N_OUT(cpu_n), .CONFIG_RESET_N_OUT(cfg_n),
    .RING_OSC_STOP_OUT(pd_osc), .PIO_STOP_OUT(pd_io),
    .SYS_CLOCK_STOP_OUT(pd_sys), .FABRIC_CLOCK_STOP_OUT(pd_fab),
    .POR_DISABLE_OUT(por_dis), .RING_OSC_SELECT_OUT(ring_sel));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Cycles with the system reset indication low
  always @(posedge clk) if (ind_n === 1'b0) low_cnt <= low_cnt + 1;
  always @(posedge clk) if (cpu_n === 1'b0) cpu_low <= cpu_low + 1;
  always @(posedge clk) if (cfg_n === 1'b0) cfg_low <= cfg_low + 1;
  // Expected cause flags per source code
  function automatic logic [10:0] cause(input int s);
    case (s)
      0: cause = 11'h001;
      1: cause = 11'h116;
      2: cause = 11'h11a;
      3: cause = 11'h310;
      4: cause = 11'h030;
      5: cause = 11'h150;
      6: cause = 11'h190;
      default: cause = 11'h510;
    endcase
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) failures++;
  endtask
  task automatic fire(input int s);
    @(posedge clk);
    go <= 1'b1;
    code <= s[3:0];
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    close_out;
  end
  initial begin
    {rstn, cyc, stb, we, go, adr, wdat, code, low_cnt} = '0;
    {cpu_low, cfg_low} = '0;
    sel = 4'hf;
    seed = 4068;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    wb(0, rcp_pkg::OFF_STAT, 0); chk("por", 32'h001, q);
    wb(0, rcp_pkg::OFF_CTRL, 0); chk("ctrl", 32'h0, q);
    wb(0, rcp_pkg::OFF_CLR, 0); chk("clr rd", 32'h0, q);
    wb(0, 8'h40, 0); chk("unmapped", 32'h0, q);
    wb(1, rcp_pkg::OFF_CTRL, 32'h0);
    for (int s = 0; s < 8; s++) begin
      wb(1, rcp_pkg::OFF_CLR, 32'h7ff);
      {low_cnt, cpu_low, cfg_low} = '0;
      if (s == 7) wb(1, rcp_pkg::OFF_CTRL, 32'h4);
      else fire(s);
      repeat (12 + ($unsigned($random(seed)) % 16)) @(posedge clk);
      e = cause(s);
      wb(0, rcp_pkg::OFF_STAT, 0);
      chk("cause", {21'h0, e}, q);
      chk("ind low", {31'h0, e[8]}, {31'h0, low_cnt != 0});
      chk("cpu low", {31'h0, e[4]}, {31'h0, cpu_low != 0});
      chk("cfg low", {31'h0, e[1]}, {31'h0, cfg_low != 0});
      if (s == 7) chk("soft len", 32'd9, low_cnt);
      wb(0, rcp_pkg::OFF_CTRL, 0); chk("self clr", 32'h0, q);
      wb(1, rcp_pkg::OFF_STAT, 32'hffffffff);
      wb(0, rcp_pkg::OFF_STAT, 0);
      chk("stat wr", {21'h0, e}, q);
      r = $random(seed);
      wb(1, rcp_pkg::OFF_CLR, r);
      wb(0, rcp_pkg::OFF_STAT, 0);
      chk("clr", {21'h0, e & ~r[10:0]}, q);
    end
    // Watchdog event and full clear land on the same edge
    fork
      fire(5);
      begin
        @(posedge clk);
        wb(1, rcp_pkg::OFF_CLR, 32'h7ff);
      end
    join
    repeat (12) @(posedge clk);
    wb(0, rcp_pkg::OFF_STAT, 0); chk("race", {21'h0, cause(5)}, q);
    wb(1, rcp_pkg::OFF_CLR, 32'h7ff);
    low_cnt = 0;
    wb(1, rcp_pkg::OFF_CTRL, 32'h0);
    repeat (12) @(posedge clk);
    wb(0, rcp_pkg::OFF_STAT, 0); chk("wr0", 32'h0, q);
    chk("wr0 ind", 32'h0, low_cnt);
    for (int k = 0; k < 4; k++) begin
      r = $random(seed) & 32'h2f;
      wb(1, rcp_pkg::OFF_PWR, r);
      chk("ext clk", 32'h0, {31'h0, ring_sel});
      chk("idle stops", 32'h0, {28'h0, pd_osc, pd_io, pd_sys, pd_fab});
      wb(1, rcp_pkg::OFF_PWR, r | 32'h10);
      repeat (2) @(posedge clk);
      chk("stops", {28'h0, r[2], r[3], r[0], r[1]},
          {28'h0, pd_osc, pd_io, pd_sys, pd_fab});
      chk("pordis", {31'h0, r[5]}, {31'h0, por_dis});
      fire(8);
      repeat (4) @(posedge clk);
      chk("wake", 32'h1, {27'h0, pd_osc, pd_io, pd_sys, pd_fab, ring_sel});
    end
    close_out;
  end
endmodule
`default_nettype wire
